// *** common/rtw_if.sv ***
// Three-wire link between host and device, resolving the shared data line.
`timescale 1ns/1ps
interface rtw_if;
   logic chip_en;
   logic sclk;
   logic host_sio_o;
   logic host_sio_oe;
   logic dev_sio_o;
   logic dev_sio_oe;
   logic bidir_data_line;

   // Line level from the enables; an undriven line idles high as with a pull-up.
   assign bidir_data_line = host_sio_oe ? host_sio_o : (dev_sio_oe ? dev_sio_o : 1'b1);

   modport host (output chip_en, output sclk, output host_sio_o, output host_sio_oe,
                 input bidir_data_line);
   modport dev  (input chip_en, input sclk, input bidir_data_line,
                 output dev_sio_o, output dev_sio_oe);
endinterface : rtw_if

// *** common/rtw_pkg.sv ***
// Shared constants and types for the three-wire real-time clock transfer port.
package rtw_pkg;

   // Clock rate of mclk_in.
   localparam int CLK_MHZ = 40;

   // Transfer format nibble codes.
   localparam logic [3:0] FMT_WR_ONE   = 4'h8;
   localparam logic [3:0] FMT_WR_BURST = 4'h0;
   localparam logic [3:0] FMT_RD_ONE   = 4'hC;
   localparam logic [3:0] FMT_RD_BURST = 4'h4;

   // Command byte layout: pointer in the upper nibble, format in the lower one.
   localparam int CMD_PTR_MSB = 7;
   localparam int CMD_PTR_LSB = 4;
   localparam int CMD_FMT_MSB = 3;
   localparam int CMD_FMT_LSB = 0;
   localparam logic [3:0] PTR_RESET = 4'h0;

   // Guard and timing figures in their own units.
   localparam int SETUP_NS     = 31000;
   localparam int GAP_NS       = 62000;
   localparam int SCLK_HALF_NS = 500;
   localparam int HOLD_MS      = 1000;

   // Derived cycle counts; least times round up, the hold limit is a longest time.
   localparam int SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYC       = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC      = HOLD_MS * 1000 * CLK_MHZ;
   localparam int CE_MAX_CYC    = HOLD_CYC - 1;

   // Counter widths.
   localparam int GCNT_W = 12;
   localparam int LCNT_W = 26;

   // Host command operations.
   typedef enum logic [1:0] {
      OP_OPEN  = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ  = 2'h2,
      OP_CLOSE = 2'h3
   } rtw_op_e;

   // Device states.
   typedef enum logic [4:0] {
      D_IDLE  = 5'h01,
      D_CMD   = 5'h02,
      D_WRITE = 5'h04,
      D_READ  = 5'h08,
      D_NOP   = 5'h10
   } rtw_dstate_e;

   // Host states.
   typedef enum logic [4:0] {
      H_IDLE  = 5'h01,
      H_OPEN  = 5'h02,
      H_SETUP = 5'h04,
      H_READY = 5'h08,
      H_SHIFT = 5'h10
   } rtw_hstate_e;

   // Address pointer step with wrap from the top address back to zero.
   function automatic logic [3:0] rtw_ptr_next(input logic [3:0] ptr);
      rtw_ptr_next = ptr + 4'h1;
   endfunction : rtw_ptr_next

endpackage : rtw_pkg

// *** src/rtw_device.sv ***
// Device end of the three-wire real-time clock transfer port.
// Summary of operation
// - Burst write stores bytes, pointer increments, wraps.
// - Burst write runs until chip-enable drops.
// - Format Ch reads one byte at pointer.
// - After single read, new command accepted.
// - Format 4h burst read increments, wraps.
// - Burst read ends, line released on chip-enable drop.
// - Single read then single write in one session.
// - Decode 8h, 0h, Ch, 4h format nibbles.
// - Hold seconds carry while chip-enable high.
// - Carry hold lasts at most one second.
// - Host keeps chip-enable high whole session.
// - Host limits chip-enable high under one second.
// - Host waits 31 us before time access.
// - Host keeps chip-enable low 62 us.
// - Host may skip guards when carry-free.
// - Clock pin outputs continuous 32.768 kHz.
// - Clock level at enable rise picks edges.
// - Command byte MSB first: pointer, format.
`timescale 1ns/1ps
module rtw_device
   import rtw_pkg::*;
#(
   parameter int HOLD_LIMIT_CYC = HOLD_CYC
) (
   input  wire logic       mclk_in,
   input  wire logic       nrst_in,
   input  wire logic       clk_en_in,
   rtw_if.dev              link,
   input  wire logic       sec_tick_in,
   input  wire logic       osc_32k_in,
   input  wire logic       upd_en_in,
   input  wire logic [3:0] upd_addr_in,
   input  wire logic [7:0] upd_data_in,
   output logic            sec_carry_out,
   output logic            clock_output_pin_out,
   output logic            wr_strobe_out,
   output logic [3:0]      wr_addr_out,
   output logic [7:0]      wr_data_out
);

   logic [7:0]        regs [0:15];
   rtw_dstate_e       state;
   logic              ce_q;
   logic              sclk_q;
   logic              edge_pol;
   logic [2:0]        bit_cnt;
   logic [7:0]        shreg;
   logic [7:0]        obyte;
   logic [3:0]        ptr;
   logic              burst;
   logic              sio_o;
   logic              sio_oe;
   logic              pend;
   logic [LCNT_W-1:0] hold_cnt;
   logic              ce_rise;
   logic              in_edge;
   logic              out_edge;
   logic [7:0]        rx_byte;
   logic              wr_now;
   logic              hold_active;

   assign link.dev_sio_o  = sio_o;
   assign link.dev_sio_oe = sio_oe;

   // Previous pin levels for edge detection; the pins are synchronous to mclk_in.
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         ce_q   <= 1'b0;
         sclk_q <= 1'b0;
      end else if (clk_en_in) begin
         ce_q   <= link.chip_en;
         sclk_q <= link.sclk;
      end
   end

   // Edge roles follow the serial clock level caught at chip-enable rise.
   assign ce_rise  = link.chip_en & ~ce_q;
   assign in_edge  = edge_pol ? (link.sclk & ~sclk_q) : (~link.sclk & sclk_q);
   assign out_edge = edge_pol ? (~link.sclk & sclk_q) : (link.sclk & ~sclk_q);
   assign rx_byte  = {shreg[6:0], link.bidir_data_line};
   // A byte that completes on the edge where chip-enable is seen low is dropped, not stored.
   assign wr_now   = link.chip_en && (state == D_WRITE) && in_edge && (bit_cnt == 3'h7);

   // Latch the edge polarity at the start of every session.
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         edge_pol <= 1'b0;
      end else if (clk_en_in && ce_rise) begin
         edge_pol <= link.sclk;
      end
   end

   // Register array; serial writes win over the local update port.
   always_ff @(posedge mclk_in) begin
      if (clk_en_in) begin
         if (wr_now) begin
            regs[ptr] <= rx_byte;
         end else if (upd_en_in) begin
            regs[upd_addr_in] <= upd_data_in;
         end
      end
   end

   // Transfer sequencer: command byte, then write, read or ignore.
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         state   <= D_IDLE;
         bit_cnt <= 3'h0;
         shreg   <= 8'h00;
         obyte   <= 8'h00;
         ptr     <= PTR_RESET;
         burst   <= 1'b0;
         sio_o   <= 1'b0;
         sio_oe  <= 1'b0;
      end else if (clk_en_in) begin
         if (!link.chip_en) begin
            // Dropping chip-enable ends any format and frees the line.
            state   <= D_IDLE;
            sio_oe  <= 1'b0;
            bit_cnt <= 3'h0;
         end else if (ce_rise) begin
            state   <= D_CMD;
            bit_cnt <= 3'h0;
         end else begin
            unique case (state)
               D_IDLE, D_NOP: begin
                  bit_cnt <= 3'h0;
               end
               D_CMD: begin
                  if (in_edge) begin
                     shreg   <= rx_byte;
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h7) begin
                        ptr <= rx_byte[CMD_PTR_MSB:CMD_PTR_LSB];
                        unique case (rx_byte[CMD_FMT_MSB:CMD_FMT_LSB])
                           FMT_WR_ONE: begin
                              state <= D_WRITE;
                              burst <= 1'b0;
                           end
                           FMT_WR_BURST: begin
                              state <= D_WRITE;
                              burst <= 1'b1;
                           end
                           FMT_RD_ONE: begin
                              state <= D_READ;
                              burst <= 1'b0;
                              obyte <= regs[rx_byte[CMD_PTR_MSB:CMD_PTR_LSB]];
                           end
                           FMT_RD_BURST: begin
                              state <= D_READ;
                              burst <= 1'b1;
                              obyte <= regs[rx_byte[CMD_PTR_MSB:CMD_PTR_LSB]];
                           end
                           default: begin
                              state <= D_NOP;
                           end
                        endcase
                     end
                  end
               end
               D_WRITE: begin
                  if (in_edge) begin
                     shreg   <= rx_byte;
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h7) begin
                        if (burst) begin
                           ptr <= rtw_ptr_next(ptr);
                        end else begin
                           state <= D_CMD;
                        end
                     end
                  end
               end
               D_READ: begin
                  // Each bit leaves on the output edge and is counted on the input edge.
                  if (out_edge) begin
                     sio_o  <= obyte[7];
                     sio_oe <= 1'b1;
                     obyte  <= {obyte[6:0], 1'b0};
                  end else if (in_edge) begin
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h7) begin
                        if (burst) begin
                           ptr   <= rtw_ptr_next(ptr);
                           obyte <= regs[rtw_ptr_next(ptr)];
                        end else begin
                           sio_oe <= 1'b0;
                           state  <= D_CMD;
                        end
                     end
                  end
               end
            endcase
         end
      end
   end

   // Local write report to the timekeeping logic.
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         wr_strobe_out <= 1'b0;
         wr_addr_out   <= 4'h0;
         wr_data_out   <= 8'h00;
      end else if (clk_en_in) begin
         wr_strobe_out <= wr_now;
         if (wr_now) begin
            wr_addr_out <= ptr;
            wr_data_out <= rx_byte;
         end
      end
   end

   // Seconds carry hold; the cap keeps a stuck chip-enable from freezing time.
   assign hold_active = link.chip_en && (hold_cnt < LCNT_W'(HOLD_LIMIT_CYC));

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         hold_cnt      <= '0;
         pend          <= 1'b0;
         sec_carry_out <= 1'b0;
      end else if (clk_en_in) begin
         if (!link.chip_en) begin
            hold_cnt <= '0;
         end else if (hold_active) begin
            hold_cnt <= hold_cnt + LCNT_W'(1);
         end
         pend          <= (sec_tick_in | pend) & hold_active;
         sec_carry_out <= (sec_tick_in | pend) & ~hold_active;
      end
   end

   // Oscillator clock retimed onto the pin; continuous, independent of the link.
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         clock_output_pin_out <= 1'b0;
      end else if (clk_en_in) begin
         clock_output_pin_out <= osc_32k_in;
      end
   end

endmodule : rtw_device

// *** src/rtw_host.sv ***
// Host end of the three-wire real-time clock transfer port.
`timescale 1ns/1ps
module rtw_host
   import rtw_pkg::*;
#(
   parameter int CE_MAX = CE_MAX_CYC
) (
   input  wire logic       mclk_in,
   input  wire logic       nrst_in,
   input  wire logic       clk_en_in,
   rtw_if.host             link,
   input  wire logic       cmd_valid_in,
   input  wire logic [1:0] cmd_op_in,
   input  wire logic [7:0] cmd_data_in,
   input  wire logic       skip_guard_in,
   output logic            ready_out,
   output logic            done_out,
   output logic [7:0]      rd_data_out,
   output logic            timeout_out
);

   rtw_hstate_e       state;
   logic              ce;
   logic              sclk;
   logic              sio_o;
   logic              sio_oe;
   logic              is_rd;
   logic [7:0]        shreg;
   logic [2:0]        bit_cnt;
   logic [GCNT_W-1:0] gcnt;
   logic [GCNT_W-1:0] low_cnt;
   logic [LCNT_W-1:0] hi_cnt;
   logic              take;

   assign link.chip_en     = ce;
   assign link.sclk        = sclk;
   assign link.host_sio_o  = sio_o;
   assign link.host_sio_oe = sio_oe;
   assign take             = cmd_valid_in && ready_out;

   // Time spent with chip-enable low and high, for the guards and the cap.
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         low_cnt <= '0;
         hi_cnt  <= '0;
      end else if (clk_en_in) begin
         if (ce) begin
            low_cnt <= '0;
            hi_cnt  <= hi_cnt + LCNT_W'(1);
         end else begin
            hi_cnt <= '0;
            if (low_cnt < GCNT_W'(GAP_CYC)) begin
               low_cnt <= low_cnt + GCNT_W'(1);
            end
         end
      end
   end

   // Session sequencer; the serial clock idles low, so the device samples on falling edges.
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         state       <= H_IDLE;
         ce          <= 1'b0;
         sclk        <= 1'b0;
         sio_o       <= 1'b0;
         sio_oe      <= 1'b0;
         is_rd       <= 1'b0;
         shreg       <= 8'h00;
         bit_cnt     <= 3'h0;
         gcnt        <= '0;
         ready_out   <= 1'b1;
         done_out    <= 1'b0;
         rd_data_out <= 8'h00;
         timeout_out <= 1'b0;
      end else if (clk_en_in) begin
         done_out    <= 1'b0;
         timeout_out <= 1'b0;
         if (ce && hi_cnt >= LCNT_W'(CE_MAX)) begin
            // A stalled session is cut off before the carry hold expires.
            state       <= H_IDLE;
            ce          <= 1'b0;
            sclk        <= 1'b0;
            sio_oe      <= 1'b0;
            ready_out   <= 1'b1;
            timeout_out <= 1'b1;
         end else begin
            unique case (state)
               H_IDLE: begin
                  if (take && rtw_op_e'(cmd_op_in) == OP_OPEN) begin
                     state     <= H_OPEN;
                     ready_out <= 1'b0;
                  end
               end
               H_OPEN: begin
                  if (skip_guard_in || low_cnt >= GCNT_W'(GAP_CYC)) begin
                     ce    <= 1'b1;
                     sclk  <= 1'b0;
                     gcnt  <= '0;
                     state <= H_SETUP;
                  end
               end
               H_SETUP: begin
                  gcnt <= gcnt + GCNT_W'(1);
                  if (skip_guard_in || gcnt >= GCNT_W'(SETUP_CYC - 1)) begin
                     state     <= H_READY;
                     ready_out <= 1'b1;
                     done_out  <= 1'b1;
                  end
               end
               H_READY: begin
                  if (take) begin
                     ready_out <= 1'b0;
                     if (rtw_op_e'(cmd_op_in) == OP_CLOSE) begin
                        ce        <= 1'b0;
                        sio_oe    <= 1'b0;
                        state     <= H_IDLE;
                        ready_out <= 1'b1;
                        done_out  <= 1'b1;
                     end else begin
                        is_rd   <= (rtw_op_e'(cmd_op_in) == OP_READ);
                        sio_oe  <= (rtw_op_e'(cmd_op_in) != OP_READ);
                        shreg   <= cmd_data_in;
                        bit_cnt <= 3'h0;
                        gcnt    <= '0;
                        state   <= H_SHIFT;
                     end
                  end
               end
               H_SHIFT: begin
                  if (gcnt >= GCNT_W'(SCLK_HALF_CYC - 1)) begin
                     gcnt <= '0;
                     if (!sclk) begin
                        // Data changes on the rise and is steady across the falling edge.
                        sclk <= 1'b1;
                        if (!is_rd) begin
                           sio_o <= shreg[7];
                        end
                     end else begin
                        sclk    <= 1'b0;
                        shreg   <= {shreg[6:0], link.bidir_data_line};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                           rd_data_out <= {shreg[6:0], link.bidir_data_line};
                           state       <= H_READY;
                           ready_out   <= 1'b1;
                           done_out    <= 1'b1;
                        end
                     end
                  end else begin
                     gcnt <= gcnt + GCNT_W'(1);
                  end
               end
            endcase
         end
      end
   end

endmodule : rtw_host

// *** testbench/rtw_link_chk.sv ***
// Wire-level assertions for the three-wire link between host and device.
`timescale 1ns/1ps
module rtw_link_chk #(
   parameter int CE_MAX = 6000
) (
   input  wire logic mclk_in,
   input  wire logic nrst_in,
   input  wire logic chip_en,
   input  wire logic sclk,
   input  wire logic host_sio_o,
   input  wire logic host_sio_oe,
   input  wire logic dev_sio_o,
   input  wire logic dev_sio_oe
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!nrst_in);

   int unsigned ce_cnt;

   // Length of the current chip-enable high interval; a stuck host shows up here.
   always_ff @(posedge mclk_in) begin
      if (!nrst_in || !chip_en)
         ce_cnt <= 0;
      else
         ce_cnt <= ce_cnt + 1;
   end

   sequence s_ce_drop;
      $fell(chip_en);
   endsequence
   sequence s_idle_two;
      !chip_en ##1 !chip_en;
   endsequence

   chk_no_fight: assert property (!(host_sio_oe && dev_sio_oe))
      else $error("host and device drive the data line together");
   chk_drop_release: assert property (s_ce_drop |=> !dev_sio_oe)
      else $error("device still drives the data line after chip-enable fell");
   chk_idle_quiet: assert property (s_idle_two |-> !dev_sio_oe && !host_sio_oe && !sclk)
      else $error("link not quiet while chip-enable is low");
   chk_open_low: assert property ($rose(chip_en) |-> !sclk)
      else $error("serial clock high when chip-enable rose");
   chk_sclk_half: assert property ($changed(sclk) |=> !$changed(sclk) [*8])
      else $error("serial clock half period too short");
   chk_host_hold: assert property ($fell(sclk) && host_sio_oe |-> $stable(host_sio_o))
      else $error("host data changed at the sampling edge");
   chk_dev_hold: assert property ($fell(sclk) && dev_sio_oe |-> $stable(dev_sio_o))
      else $error("device data changed at the sampling edge");
   chk_ce_bound: assert property (ce_cnt <= CE_MAX + 2)
      else $error("chip-enable high for too long");
   chk_sclk_session: assert property (sclk |-> chip_en)
      else $error("serial clock toggles outside a session");
   chk_dev_turn: assert property ($rose(dev_sio_oe) |-> chip_en && !host_sio_oe)
      else $error("device takes the line at a wrong moment");
endmodule : rtw_link_chk

// *** testbench/rtw_three_wire_transfer_port_tb.sv ***
// Testbench joining the host and device ends across the three-wire link.
`timescale 1ns/1ps
module rtw_three_wire_transfer_port_tb;
   import rtw_pkg::*;
   localparam int HOLD_LIM = 2000;
   localparam int CE_LIM   = 6000;
   logic       mclk_in, nrst_in, cmd_valid, skip, sec_tick, osc, osc_d, upd_en, sclk_d, ce_d;
   logic [1:0] cmd_op;
   logic [2:0] osc_div;
   logic [3:0] upd_addr, wr_addr;
   logic [7:0] cmd_data, upd_data, rd_data, wr_data, sh;
   logic       ready, done, tmo, carry, clk_pin, wr_stb;
   int         errors, checked, strobes, carries, oe_cnt, hi_cnt, lo_cnt, last_lo;
   rtw_if bus();

   rtw_host #(.CE_MAX(CE_LIM)) rtw_host_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .clk_en_in(1'b1), .link(bus.host), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
      .cmd_data_in(cmd_data), .skip_guard_in(skip), .ready_out(ready), .done_out(done),
      .rd_data_out(rd_data), .timeout_out(tmo));
   rtw_device #(.HOLD_LIMIT_CYC(HOLD_LIM)) rtw_device_inst (.mclk_in(mclk_in),
      .nrst_in(nrst_in), .clk_en_in(1'b1), .link(bus.dev), .sec_tick_in(sec_tick),
      .osc_32k_in(osc), .upd_en_in(upd_en), .upd_addr_in(upd_addr), .upd_data_in(upd_data),
      .sec_carry_out(carry), .clock_output_pin_out(clk_pin), .wr_strobe_out(wr_stb),
      .wr_addr_out(wr_addr), .wr_data_out(wr_data));
   rtw_link_chk #(.CE_MAX(CE_LIM)) rtw_link_chk_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .chip_en(bus.chip_en), .sclk(bus.sclk), .host_sio_o(bus.host_sio_o),
      .host_sio_oe(bus.host_sio_oe), .dev_sio_o(bus.dev_sio_o), .dev_sio_oe(bus.dev_sio_oe));

   // The 40 MHz clock.
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end

   // Wire monitor and a fast stand-in oscillator; the oscillator rate is not real, only shape.
   always @(posedge mclk_in) begin
      sclk_d <= bus.sclk;
      ce_d <= bus.chip_en;
      if (sclk_d === 1'b1 && bus.sclk === 1'b0)
         sh <= {sh[6:0], bus.bidir_data_line};
      if (wr_stb === 1'b1)
         strobes <= strobes + 1;
      if (carry === 1'b1)
         carries <= carries + 1;
      if (bus.dev_sio_oe === 1'b1)
         oe_cnt <= oe_cnt + 1;
      hi_cnt <= (bus.chip_en === 1'b1) ? hi_cnt + 1 : 0;
      lo_cnt <= (bus.chip_en === 1'b1) ? 0 : lo_cnt + 1;
      if (bus.chip_en === 1'b1 && ce_d === 1'b0)
         last_lo <= lo_cnt;
      osc_div <= osc_div + 3'h1;
      if (osc_div == 3'h7)
         osc <= ~osc;
      osc_d <= osc;
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   // One host request, held until taken, then a bounded wait for its completion.
   task automatic op(input logic [1:0] o, input logic [7:0] d);
      int n;
      @(posedge mclk_in);
      cmd_valid <= 1'b1;
      cmd_op <= o;
      cmd_data <= d;
      @(posedge mclk_in);
      for (n = 0; n < 9000 && ready !== 1'b1; n++)
         @(posedge mclk_in);
      cmd_valid <= 1'b0;
      for (n = 0; n < 9000 && done !== 1'b1; n++)
         @(posedge mclk_in);
      if (n == 9000) begin
         errors++;
         $display("ERROR t=%0t no completion", $time);
      end
      repeat (3) @(posedge mclk_in);
   endtask : op

   task automatic wr(input logic [7:0] d);
      op(OP_WRITE, d);
      chk8(sh, d);
   endtask : wr

   task automatic wrchk(input logic [7:0] d, input logic [3:0] a);
      wr(d);
      chk8(wr_data, d);
      chk8({4'h0, wr_addr}, {4'h0, a});
   endtask : wrchk

   task automatic rd(input logic [7:0] e);
      op(OP_READ, 8'h00);
      chk8(rd_data, e);
      chk8(sh, e);
   endtask : rd

   task automatic open(input logic s);
      skip <= s;
      op(OP_OPEN, 8'h00);
   endtask : open

   task automatic tick();
      @(posedge mclk_in);
      sec_tick <= 1'b1;
      @(posedge mclk_in);
      sec_tick <= 1'b0;
   endtask : tick

   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   // Hang guard, about three and a half times the expected run length.
   initial begin
      repeat (70000) @(posedge mclk_in);
      errors++;
      $display("ERROR t=%0t run hung", $time);
      close_out();
   end

   // Main sequence.
   initial begin
      int c;
      nrst_in = 1'b0;
      {cmd_valid, skip, sec_tick, osc, upd_en, cmd_op, cmd_data, osc_div} = '0;
      {upd_addr, upd_data, sh, sclk_d, ce_d, osc_d} = '0;
      {errors, checked, strobes, carries, oe_cnt, hi_cnt, lo_cnt, last_lo} = '0;
      repeat (2) @(posedge mclk_in);
      nrst_in <= 1'b1;
      open(1'b1);
      wr(8'hE0);
      wrchk(8'h11, 4'hE);
      wrchk(8'h22, 4'hF);
      wrchk(8'h33, 4'h0);
      wrchk(8'h44, 4'h1);
      op(OP_CLOSE, 8'h00);
      chk8(8'(strobes), 8'h04);
      $display("burst write finished");
      open(1'b1);
      wr(8'hF4);
      rd(8'h22);
      rd(8'h33);
      rd(8'h44);
      op(OP_CLOSE, 8'h00);
      chk8({7'h0, bus.dev_sio_oe}, 8'h00);
      $display("burst read finished");
      @(posedge mclk_in);
      upd_en <= 1'b1;
      upd_addr <= 4'h5;
      upd_data <= 8'h96;
      @(posedge mclk_in);
      upd_en <= 1'b0;
      open(1'b1);
      wr(8'h5C);
      rd(8'h96);
      wr(8'hE8);
      wrchk(8'h5A, 4'hE);
      wr(8'h0C);
      rd(8'h33);
      wr(8'hEC);
      rd(8'h5A);
      op(OP_CLOSE, 8'h00);
      $display("single transfers finished");
      c = strobes + oe_cnt;
      open(1'b1);
      wr(8'hE2);
      wr(8'hFF);
      wr(8'hEC);
      op(OP_CLOSE, 8'h00);
      chk8(8'(strobes + oe_cnt), 8'(c));
      open(1'b0);
      chk8({7'h0, last_lo >= GAP_CYC}, 8'h01);
      chk8({7'h0, hi_cnt >= SETUP_CYC}, 8'h01);
      wr(8'hEC);
      rd(8'h5A);
      op(OP_CLOSE, 8'h00);
      $display("unknown format and guards finished");
      c = carries;
      open(1'b1);
      tick();
      repeat (100) @(posedge mclk_in);
      chk8(8'(carries), 8'(c));
      op(OP_CLOSE, 8'h00);
      chk8(8'(carries), 8'(c + 1));
      open(1'b1);
      tick();
      repeat (HOLD_LIM + 20) @(posedge mclk_in);
      chk8(8'(carries), 8'(c + 2));
      op(OP_CLOSE, 8'h00);
      tick();
      repeat (3) @(posedge mclk_in);
      chk8(8'(carries), 8'(c + 3));
      $display("carry hold finished");
      open(1'b1);
      for (c = 0; c < CE_LIM + 50 && tmo !== 1'b1; c++)
         @(posedge mclk_in);
      chk8({7'h0, tmo}, 8'h01);
      repeat (3) @(posedge mclk_in);
      chk8({7'h0, bus.chip_en}, 8'h00);
      repeat (40) begin
         @(posedge mclk_in);
         chk8({7'h0, clk_pin}, {7'h0, osc_d});
      end
      $display("timeout and clock pin finished");
      close_out();
   end
endmodule : rtw_three_wire_transfer_port_tb
